// ==== inc/aeu_defs.vh ====
`ifndef AEU_DEFS_VH
`define AEU_DEFS_VH

// Operation select codes.
`define AEU_OP_ADD          4'h0
`define AEU_OP_ADC          4'h1
`define AEU_OP_SUB          4'h2
`define AEU_OP_DIFF_BRW     4'h3
`define AEU_OP_IMM_DIFF     4'h4
`define AEU_OP_IMM_DIFF_BRW 4'h5
`define AEU_OP_AND          4'h6
`define AEU_OP_IMM_CONJ     4'h7
`define AEU_OP_OR           4'h8
`define AEU_OP_ORI          4'h9
`define AEU_OP_WORD_INC     4'hA
`define AEU_OP_WORD_DEC     4'hB

// Status flag bit positions in the 8-bit status byte.
`define AEU_F_C           0
`define AEU_F_Z           1
`define AEU_F_N           2
`define AEU_F_V           3
`define AEU_F_S           4
`define AEU_F_H           5
`define AEU_F_T           6
`define AEU_F_I           7

// Reset values.
`define AEU_SREG_RST      8'h00
`define AEU_DATA_RST      8'h00

// Cycle counts per operation class.
`define AEU_CYC_BYTE      2'h1
`define AEU_CYC_WORD      2'h2

`endif

// ==== core/aeu_flag_reg.v ====
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defs.vh"

// Holds the status byte; only the flags selected by the mask are replaced.
module aeu_flag_reg
(
  // Clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // Update
  input  wire       upd,
  input  wire [7:0] upd_mask,
  input  wire [7:0] upd_val,
  // State
  output reg  [7:0] flags
);

  always @(posedge clk_sys)
  begin
    if (!resetn)
      flags <= `AEU_SREG_RST;
    else if (upd)
      flags <= (flags & ~upd_mask) | (upd_val & upd_mask);
  end

endmodule
`default_nettype wire

// ==== core/aeu_core.v ====
// Behaviour
// RULE1 - Register add and add-with-carry store Rd plus source (plus C) and update Z C N V H in one clock.
// RULE2 - Word immediate increase adds K to the high:low pair, updates Z C N V S and takes two clocks.
// RULE3 - Word immediate decrease subtracts K from the high:low pair, updates Z C N V S, two clocks.
// RULE4 - Register subtract and difference with borrow store Rd minus source (minus C), Z C N V H, one clock.
// RULE5 - Immediate difference stores Rd minus K and updates Z C N V H in one clock.
// RULE6 - Immediate difference with borrow stores Rd minus K minus C and updates Z C N V H in one clock.
// RULE7 - Conjunction and disjunction with a register or constant store into Rd and update only Z N V.
// RULE8 - Bitwise operations clear V, copy result bit 7 to N and set Z when the result is zero.
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defs.vh"

module aeu_core
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // Request from decoder
  input  wire        op_start,
  input  wire [3:0]  op_sel,
  input  wire [7:0]  dest_operand,
  input  wire [7:0]  dest_high,
  input  wire [7:0]  source_operand,
  input  wire [7:0]  imm_operand,
  // Result to register file
  output reg         res_valid,
  output reg         res_word,
  output reg  [7:0]  res_low,
  output reg  [7:0]  res_high,
  output reg         busy,
  output reg  [1:0]  op_cycles,
  // Status flags
  output wire [7:0]  status_flags
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WORD = 2'b10;

  reg  [1:0]  state;
  reg  [15:0] word_sum;
  reg  [7:0]  next_flags;
  reg  [7:0]  flag_mask;
  reg  [7:0]  byte_res;
  reg         flag_upd;
  reg  [8:0]  wide;
  reg  [7:0]  opb;
  reg         cin;
  reg         is_sub;
  reg  [16:0] wsum;
  wire [7:0]  flags;

  // Half carry out of bit 3 for add or borrow out of bit 3 for subtract.
  function half_flag;
    input       sub;
    input [7:0] a;
    input [7:0] b;
    input [7:0] r;
    begin
      if (sub)
        half_flag = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      else
        half_flag = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
    end
  endfunction

  // Two's complement overflow from the operand and result sign bits.
  function ovf_flag;
    input sub;
    input a7;
    input b7;
    input r7;
    begin
      if (sub)
        ovf_flag = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
      else
        ovf_flag = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
    end
  endfunction

  aeu_flag_reg u_flags
  (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .upd      (flag_upd),
    .upd_mask (flag_mask),
    .upd_val  (next_flags),
    .flags    (flags)
  );

  assign status_flags = flags;

  always @*
  begin
    next_flags = `AEU_SREG_RST;
    flag_mask  = 8'h00;
    byte_res   = 8'h00;
    flag_upd   = 1'b0;
    wide       = 9'h000;
    is_sub     = 1'b0;
    cin        = 1'b0;
    opb        = source_operand;
    // The pair result is formed every cycle; only a taken word request latches it.
    if (op_sel == `AEU_OP_WORD_INC)
      wsum = {1'b0, dest_high, dest_operand} + {9'h000, imm_operand}; // RULE2
    else
      wsum = {1'b0, dest_high, dest_operand} - {9'h000, imm_operand}; // RULE3
    case (op_sel)
      `AEU_OP_IMM_DIFF, `AEU_OP_IMM_DIFF_BRW, `AEU_OP_IMM_CONJ, `AEU_OP_ORI:
        opb = imm_operand;
      default:
        opb = source_operand;
    endcase
    case (op_sel)
      `AEU_OP_ADC, `AEU_OP_DIFF_BRW, `AEU_OP_IMM_DIFF_BRW:
        cin = flags[`AEU_F_C];
      default:
        cin = 1'b0;
    endcase
    if (op_start && state == ST_IDLE)
    begin
      case (op_sel)
        `AEU_OP_ADD, `AEU_OP_ADC:
        begin
          wide = {1'b0, dest_operand} + {1'b0, opb} + {8'h00, cin}; // RULE1
          byte_res = wide[7:0];
          flag_upd = 1'b1;
          flag_mask = 8'h2F;
        end
        `AEU_OP_SUB, `AEU_OP_DIFF_BRW, `AEU_OP_IMM_DIFF, `AEU_OP_IMM_DIFF_BRW:
        begin
          wide = {1'b0, dest_operand} - {1'b0, opb} - {8'h00, cin}; // RULE4 RULE5 RULE6
          byte_res = wide[7:0];
          is_sub = 1'b1;
          flag_upd = 1'b1;
          flag_mask = 8'h2F;
        end
        `AEU_OP_AND, `AEU_OP_IMM_CONJ:
        begin
          byte_res = dest_operand & opb; // RULE7
          flag_upd = 1'b1;
          flag_mask = 8'h0E;
        end
        `AEU_OP_OR, `AEU_OP_ORI:
        begin
          byte_res = dest_operand | opb; // RULE7
          flag_upd = 1'b1;
          flag_mask = 8'h0E;
        end
        default:
          flag_upd = 1'b0;
      endcase
      next_flags[`AEU_F_C] = wide[8];
      next_flags[`AEU_F_Z] = (byte_res == 8'h00); // RULE8
      next_flags[`AEU_F_N] = byte_res[7]; // RULE8
      if (flag_mask == 8'h2F)
      begin
        next_flags[`AEU_F_V] = ovf_flag(is_sub, dest_operand[7], opb[7], byte_res[7]);
        next_flags[`AEU_F_H] = half_flag(is_sub, dest_operand, opb, byte_res);
      end
      else
        next_flags[`AEU_F_V] = 1'b0; // RULE8
    end
    else if (state == ST_WORD)
    begin
      // Second clock of a word operation commits the 16-bit flags.
      flag_upd = 1'b1;
      flag_mask = 8'h1F;
      next_flags[`AEU_F_Z] = (word_sum == 16'h0000); // RULE2 RULE3
      next_flags[`AEU_F_N] = word_sum[15];
      next_flags[`AEU_F_C] = res_word;
      next_flags[`AEU_F_V] = op_cycles[0];
      next_flags[`AEU_F_S] = word_sum[15] ^ op_cycles[0];
    end
  end

  // For word operations the carry and overflow are parked in res_word and
  // op_cycles[0] during the first clock so the flag update can use them.
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state     <= ST_IDLE;
      res_valid <= 1'b0;
      res_word  <= 1'b0;
      res_low   <= `AEU_DATA_RST;
      res_high  <= `AEU_DATA_RST;
      busy      <= 1'b0;
      op_cycles <= 2'h0;
      word_sum  <= 16'h0000;
    end
    else
    begin
      res_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (op_start && (op_sel == `AEU_OP_WORD_INC || op_sel == `AEU_OP_WORD_DEC))
          begin
            word_sum  <= wsum[15:0];
            res_word  <= wsum[16];
            op_cycles <= {1'b0, (op_sel == `AEU_OP_WORD_INC) ?
                         (~dest_high[7] & wsum[15]) : (dest_high[7] & ~wsum[15])};
            busy      <= 1'b1;
            state     <= ST_WORD;
          end
          else if (op_start && flag_upd)
          begin
            res_low   <= byte_res;
            res_valid <= 1'b1;
            res_word  <= 1'b0;
            op_cycles <= `AEU_CYC_BYTE;
          end
        end
        ST_WORD:
        begin
          res_low   <= word_sum[7:0];
          res_high  <= word_sum[15:8];
          res_valid <= 1'b1;
          res_word  <= 1'b1;
          op_cycles <= `AEU_CYC_WORD;
          busy      <= 1'b0;
          state     <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== dv/aeu_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defs.vh"
module aeu_core_props
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // Request
  input wire logic       op_start,
  input wire logic [3:0] op_sel,
  input wire logic [7:0] dest_operand,
  input wire logic [7:0] dest_high,
  input wire logic [7:0] source_operand,
  input wire logic [7:0] imm_operand,
  // Result
  input wire logic       res_valid,
  input wire logic       res_word,
  input wire logic [7:0] res_low,
  input wire logic [7:0] res_high,
  input wire logic       busy,
  input wire logic [1:0] op_cycles,
  input wire logic [7:0] status_flags
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  wire tk = op_start && !busy;
  wire lg = op_sel >= `AEU_OP_AND && op_sel <= `AEU_OP_ORI;
  wire wd = op_sel == `AEU_OP_WORD_INC || op_sel == `AEU_OP_WORD_DEC;
  sequence s_word_done;
    busy ##1 (res_valid && res_word && op_cycles == 2'h2);
  endsequence
  a_byte_one_clk: assert property (
    tk && op_sel <= `AEU_OP_ORI |=> res_valid && !res_word && op_cycles == 2'h1)
    else $error("byte op late");
  a_word_two_clk: assert property (tk && wd |=> s_word_done)
    else $error("word op timing");
  a_add_sum: assert property (
    tk && op_sel == `AEU_OP_ADD |=> res_low == $past(dest_operand + source_operand))
    else $error("add result");
  a_sub_diff: assert property (
    tk && op_sel == `AEU_OP_SUB |=> res_low == $past(dest_operand - source_operand))
    else $error("sub result");
  a_imm_diff: assert property (
    tk && op_sel == `AEU_OP_IMM_DIFF |=> res_low == $past(dest_operand - imm_operand))
    else $error("imm diff result");
  a_imm_borrow: assert property (tk && op_sel == `AEU_OP_IMM_DIFF_BRW |=>
    res_low == $past(dest_operand - imm_operand - status_flags[0]))
    else $error("imm borrow result");
  a_logic_flags: assert property (tk && lg |=> !status_flags[3] &&
    status_flags[2] == res_low[7] && status_flags[1] == (res_low == 8'h00))
    else $error("logic flags");
  a_logic_keep: assert property (tk && lg |=>
    $stable(status_flags[0]) && $stable(status_flags[5]))
    else $error("logic touched C or H");
  a_word_sum: assert property (tk && op_sel == `AEU_OP_WORD_INC |=> ##1
    {res_high, res_low} == $past({dest_high, dest_operand} + imm_operand, 2))
    else $error("word sum");
  a_word_diff: assert property (tk && op_sel == `AEU_OP_WORD_DEC |=> ##1
    {res_high, res_low} == $past({dest_high, dest_operand} - imm_operand, 2))
    else $error("word diff");
endmodule
bind aeu_core aeu_core_props u_props (.clk_sys(clk_sys), .resetn(resetn),
  .op_start(op_start), .op_sel(op_sel), .dest_operand(dest_operand),
  .dest_high(dest_high), .source_operand(source_operand), .imm_operand(imm_operand),
  .res_valid(res_valid), .res_word(res_word), .res_low(res_low), .res_high(res_high),
  .busy(busy), .op_cycles(op_cycles), .status_flags(status_flags));
`default_nettype wire

// ==== dv/aeu_dec_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module aeu_dec_model
(
  // From bench
  input wire logic        go,
  input wire logic [3:0]  sel,
  input wire logic [7:0]  a,
  input wire logic [7:0]  h,
  input wire logic [7:0]  s,
  input wire logic [7:0]  k,
  // To unit
  output wire logic       op_start,
  output wire logic [3:0] op_sel,
  output wire logic [7:0] dest_operand,
  output wire logic [7:0] dest_high,
  output wire logic [7:0] source_operand,
  output wire logic [7:0] imm_operand
);
  // Outside a request the operands are inverted, so a late sample shows up.
  assign op_start = go;
  assign op_sel = go ? sel : ~sel;
  assign dest_operand = go ? a : ~a;
  assign dest_high = go ? h : ~h;
  assign source_operand = go ? s : ~s;
  assign imm_operand = go ? k : ~k;
endmodule
`default_nettype wire

// ==== dv/aeu_core_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aeu_defs.vh"
module aeu_core_test;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       go = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] a = 8'h00, h = 8'h00, s = 8'h00, k = 8'h00;
  wire        op_start, res_valid, res_word, busy;
  wire  [3:0] op_sel;
  wire  [1:0] op_cycles;
  wire  [7:0] d_o, h_o, s_o, k_o, res_low, res_high, status_flags;
  int         bad_count = 0;
  int         checked = 0;
  always #50 clk_sys = ~clk_sys;
  aeu_dec_model u_dec (.go(go), .sel(sel), .a(a), .h(h), .s(s), .k(k),
    .op_start(op_start), .op_sel(op_sel), .dest_operand(d_o), .dest_high(h_o),
    .source_operand(s_o), .imm_operand(k_o));
  aeu_core u_dut (.clk_sys(clk_sys), .resetn(resetn), .op_start(op_start),
    .op_sel(op_sel), .dest_operand(d_o), .dest_high(h_o), .source_operand(s_o),
    .imm_operand(k_o), .res_valid(res_valid), .res_word(res_word), .res_low(res_low),
    .res_high(res_high), .busy(busy), .op_cycles(op_cycles), .status_flags(status_flags));
  task conclude;
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task run(input logic [3:0] op, input logic [7:0] d, hi, sr, kk,
           input logic [15:0] er, input logic [7:0] ef);
    int   n;
    logic w;
    w = (op >= `AEU_OP_WORD_INC);
    @(negedge clk_sys);
    sel = op; a = d; h = hi; s = sr; k = kk; go = 1'b1;
    @(negedge clk_sys);
    go = 1'b0;
    n = 0;
    while (res_valid !== 1'b1 && n < 4)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({res_valid, res_word, op_cycles, w ? res_high : 8'h00, res_low, ef},
        {1'b1, w, w ? 2'h2 : 2'h1, er, status_flags});
  endtask
  task t_reset;
    chk({res_valid, res_word, busy, op_cycles, res_low, res_high, status_flags}, 32'h0);
  endtask
  task t_add;
    run(`AEU_OP_ADD, 8'hFF, 8'h00, 8'h01, 8'h00, 16'h0000, 8'h23);
    run(`AEU_OP_ADC, 8'h7F, 8'h00, 8'h00, 8'h00, 16'h0080, 8'h2C);
  endtask
  task t_logic;
    run(`AEU_OP_AND, 8'hC3, 8'h00, 8'h3C, 8'h00, 16'h0000, 8'h22);
    run(`AEU_OP_SUB, 8'h00, 8'h00, 8'h01, 8'h00, 16'h00FF, 8'h25);
    run(`AEU_OP_AND, 8'h80, 8'h00, 8'hFF, 8'h00, 16'h0080, 8'h25);
    run(`AEU_OP_IMM_CONJ, 8'h0F, 8'h00, 8'hFF, 8'hF0, 16'h0000, 8'h23);
    run(`AEU_OP_OR, 8'h80, 8'h00, 8'h01, 8'h00, 16'h0081, 8'h25);
    run(`AEU_OP_ORI, 8'h00, 8'h00, 8'hFF, 8'h00, 16'h0000, 8'h23);
  endtask
  task t_borrow;
    run(`AEU_OP_DIFF_BRW, 8'h10, 8'h00, 8'h00, 8'hFF, 16'h000F, 8'h20);
    run(`AEU_OP_IMM_DIFF, 8'h00, 8'h00, 8'hFF, 8'h01, 16'h00FF, 8'h25);
    run(`AEU_OP_IMM_DIFF_BRW, 8'h05, 8'h00, 8'hFF, 8'h04, 16'h0000, 8'h02);
  endtask
  task t_word;
    run(`AEU_OP_WORD_INC, 8'hFF, 8'hFF, 8'h00, 8'h01, 16'h0000, 8'h03);
    run(`AEU_OP_WORD_INC, 8'hFF, 8'h7F, 8'h00, 8'h01, 16'h8000, 8'h0C);
    run(`AEU_OP_WORD_DEC, 8'h00, 8'h00, 8'h00, 8'h01, 16'hFFFF, 8'h15);
  endtask
  // The request is held into the busy clock, where it must be ignored; H must survive.
  task t_busy;
    @(negedge clk_sys);
    sel = `AEU_OP_WORD_INC; a = 8'h01; h = 8'h00; k = 8'h01; go = 1'b1;
    repeat (2) @(negedge clk_sys);
    go = 1'b0;
    chk({res_valid, res_word, res_high, res_low, status_flags}, {2'b11, 16'h0002, 8'h20});
    @(negedge clk_sys);
    chk({res_valid, busy, res_high, res_low}, {2'b00, 16'h0002});
  endtask
  initial
  begin
    repeat (16) @(negedge clk_sys);
    t_reset;
    resetn = 1'b1;
    t_add;
    t_logic;
    t_borrow;
    t_word;
    // A reset in mid-run must drop every result and flag back to zero.
    @(negedge clk_sys);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    t_reset;
    resetn = 1'b1;
    t_add;
    t_busy;
    conclude;
  end
  initial
  begin
    #100000;
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire
